// file: emdp_pkg.sv
// Package of constants, types and field layouts for the EDC mode/diagnostic block
package emdp_pkg;
    // ==========================================================
    // Widths
    localparam int DATA_W = 64;
    localparam int CB_W = 8;
    localparam int MODE_W = 16;
    localparam int CNT_W = 4;
    // ==========================================================
    // Mode register layout and reset value
    localparam int MODE_CODE_LO = 0;
    localparam int MODE_CLEAR_BIT = 3;
    localparam int MODE_PSEL_BIT = 5;
    localparam int MODE_RMODE_BIT = 6;
    localparam logic [15:0] MODE_RESET = 16'h0003;
    // ==========================================================
    // Diagnostic readout layout on the system data bus
    localparam int DG_CBI_LO = 0;
    localparam int DG_CB_LO = 8;
    localparam int DG_SYN1_LO = 16;
    localparam int DG_CNT_LO = 24;
    localparam int DG_ERR_BIT = 28;
    localparam int DG_MULTI_BIT_ERROR_FLAG_BIT = 29;
    localparam int DG_SYN_LO = 30;
    // ==========================================================
    // Code constants
    localparam logic [7:0] ZERO_CHECKBITS = 8'h0C;
    localparam logic [3:0] CNT_MAX = 4'hF;
    localparam logic [7:0] BE_ALL = 8'hFF;
    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        EMDP_MODE_ERR_DATA,
        EMDP_MODE_DIAG,
        EMDP_MODE_GEN_DETECT,
        EMDP_MODE_NORMAL,
        EMDP_MODE_INJECT
    } emdp_mode_t;
    typedef struct packed {
        logic [63:0] data;
        logic [7:0] cb;
        logic [7:0] syn;
        logic err;
        logic multi_bit_error_flag;
    } emdp_read_t;
endpackage

// file: emdp_core.sv
// EDC operating modes, diagnostic logging and byte parity, single clock
// Operation
// [R1] Mode 0 drives error-data register on system bus; clear zeroes it.
// [R2] Mode 1 drives checkbit-input latch and diagnostic registers on system bus.
// [R3] Checkbit-input latch is readable directly in diagnostic output mode.
// [R4] Mode 2 generates checkbits on writes, detects but never corrects on reads.
// [R5] Mode 3 generates checkbits on writes, detects and corrects single-bit errors.
// [R6] Mode 4 loads the memory checkbit latch from system data bits 7..0.
// [R7] Mode 4 reads compare injected checkbits; any mismatch drives error flags low. Code lowers multi_bit_error_flag_n_out only for multi-bit mismatches.
// [R8] All-zero data word produces checkbits 0C.
// [R9] Host initialises memory: clear, then write in mode 0, bytes on, buffer select low.
// [R10] Six diagnostic registers load on syndrome clock rising edge with an error.
// [R11] Error data, checkbits, type, first syndrome load only on first error.
// [R12] Latest syndrome and error count update on every logged error.
// [R13] Readout bit 28 marks any error, bit 29 a multiple-bit error.
// [R14] Error data readable only in mode 0; others only in mode 1.
// [R15] Memory reads produce one parity bit per byte on the parity bus.
// [R16] Memory writes compare supplied parity with generated parity, flag mismatches.
// [R17] Partial writes check parity only on enabled system-side bytes.
// [R18] Mode register takes system data 15..0 when its enable is high.
// [R19] Error count saturates at fifteen; clear resets it to zero.
// [R20] First-error-seen flag set by first logged error, reset by clear.
module emdp_core
    import emdp_pkg::*;
(
    input logic sys_clk_in,
    input logic rst_in,
    input logic mode_register_enable_in,
    input logic sys_read_in,
    input logic mem_read_in,
    input logic mem_write_in,
    input logic write_buffer_select_in,
    input logic syndrome_clock_in,
    input logic [7:0] byte_enables_in,
    input logic [63:0] system_data_bus_in,
    input logic [7:0] system_parity_bus_in,
    input logic [63:0] memory_data_bus_in,
    input logic [7:0] checkbit_input_in,
    output logic [63:0] system_data_bus_out,
    output logic system_data_bus_oe_n_out,
    output logic [7:0] system_parity_bus_out,
    output logic system_parity_bus_oe_n_out,
    output logic [63:0] memory_data_bus_out,
    output logic [7:0] memory_checkbit_out,
    output logic error_flag_n_out,
    output logic multi_bit_error_flag_n_out,
    output logic parity_error_flag_n_out
);
    // ==========================================================
    // Code helpers
    // Column of the check matrix: odd weight 3 or 5, so single errors never alias
    function automatic logic [7:0] code_col(input int idx);
        int n;
        logic [7:0] v;
        code_col = 8'h00;
        n = 0;
        for (int k = 0; k < 256; k++) begin
            v = k[7:0];
            if ($countones(v) == 3 || $countones(v) == 5) begin
                if (n == idx) begin
                    code_col = v;
                end
                n++;
            end
        end
    endfunction

    // [R8] zero word gives 0C
    function automatic logic [7:0] gen_cb(input logic [63:0] d);
        gen_cb = ZERO_CHECKBITS;
        for (int i = 0; i < DATA_W; i++) begin
            if (d[i]) begin
                gen_cb = gen_cb ^ code_col(i);
            end
        end
    endfunction

    // One parity bit per byte, inverted for odd parity
    function automatic logic [7:0] byte_par(input logic [63:0] d, input logic odd);
        for (int b = 0; b < 8; b++) begin
            byte_par[b] = ^d[8*b +: 8] ^ odd;
        end
    endfunction

    // ==========================================================
    // Mode register and latches
    logic [15:0] mode_reg, next_mode_reg;
    logic [7:0] cbi_latch, next_cbi_latch;
    logic [7:0] inj_latch, next_inj_latch;
    logic clr_pulse, next_clr_pulse;
    emdp_mode_t mode;
    logic odd_par;

    assign mode = emdp_mode_t'(mode_reg[MODE_CODE_LO +: 3]);
    assign odd_par = mode_reg[MODE_PSEL_BIT];

    // Latch updates; clear acts once, on the write that sets the bit
    always_comb begin
        next_mode_reg = mode_reg;
        next_cbi_latch = cbi_latch;
        next_inj_latch = inj_latch;
        next_clr_pulse = 1'b0;
        // [R18] mode register capture
        if (mode_register_enable_in) begin
            next_mode_reg = system_data_bus_in[15:0];
            next_clr_pulse = system_data_bus_in[MODE_CLEAR_BIT];
        end
        if (mem_read_in) begin
            next_cbi_latch = checkbit_input_in;
        end
        // [R6] checkbit injection load
        if (mem_write_in && mode == EMDP_MODE_INJECT) begin
            next_inj_latch = system_data_bus_in[7:0];
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_reg <= MODE_RESET;
            cbi_latch <= 8'h00;
            inj_latch <= 8'h00;
            clr_pulse <= 1'b0;
        end else begin
            mode_reg <= next_mode_reg;
            cbi_latch <= next_cbi_latch;
            inj_latch <= next_inj_latch;
            clr_pulse <= next_clr_pulse;
        end
    end

    // ==========================================================
    // Read decode
    emdp_read_t rd_now, rd_q, next_rd_q;
    logic [63:0] flip, rd_data;
    logic [7:0] cb_cmp;

    // Syndrome, single-bit locate and multi-bit classification
    always_comb begin
        // [R7] injected checkbits stand in for memory checkbits
        cb_cmp = (mode == EMDP_MODE_INJECT) ? inj_latch : checkbit_input_in;
        rd_now.data = memory_data_bus_in;
        rd_now.cb = cb_cmp;
        rd_now.syn = gen_cb(memory_data_bus_in) ^ cb_cmp;
        flip = 64'h0;
        for (int i = 0; i < DATA_W; i++) begin
            flip[i] = (rd_now.syn == code_col(i));
        end
        rd_now.err = |rd_now.syn;
        rd_now.multi_bit_error_flag = rd_now.err && !(|flip) && ($countones(rd_now.syn) != 1);
        // [R4] detect-only path
        // [R5] correct single-bit errors
        if (mode == EMDP_MODE_GEN_DETECT) begin
            rd_data = memory_data_bus_in;
        end else begin
            rd_data = memory_data_bus_in ^ flip;
        end
        next_rd_q = mem_read_in ? rd_now : rd_q;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_q <= '0;
        end else begin
            rd_q <= next_rd_q;
        end
    end

    // ==========================================================
    // Syndrome clock synchroniser; first stage feeds only the second
    logic syn_s1, syn_s2, syn_s3;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            syn_s1 <= 1'b0;
            syn_s2 <= 1'b0;
            syn_s3 <= 1'b0;
        end else begin
            syn_s1 <= syndrome_clock_in;
            syn_s2 <= syn_s1;
            syn_s3 <= syn_s2;
        end
    end

    // ==========================================================
    // Diagnostic registers
    logic [63:0] err_data, next_err_data;
    logic [7:0] diag_cb, next_diag_cb, syn_first, next_syn_first;
    logic [7:0] syn_last, next_syn_last;
    logic [3:0] error_tally, next_error_tally;
    logic [1:0] err_type, next_err_type;
    logic first_seen, next_first_seen;
    logic log_err;

    // [R10] log on synchronised syndrome clock rise with an error held
    assign log_err = syn_s2 && !syn_s3 && rd_q.err;

    // A log in the clear cycle wins: it lands on freshly zeroed registers
    always_comb begin
        next_err_data = err_data;
        next_diag_cb = diag_cb;
        next_syn_first = syn_first;
        next_err_type = err_type;
        next_syn_last = syn_last;
        next_error_tally = error_tally;
        next_first_seen = first_seen;
        // [R1] clear zeroes all diagnostics
        if (clr_pulse) begin
            next_err_data = 64'h0;
            next_diag_cb = 8'h00;
            next_syn_first = 8'h00;
            next_err_type = 2'b00;
            next_syn_last = 8'h00;
            next_error_tally = 4'h0;
            next_first_seen = 1'b0;
        end
        if (log_err) begin
            // [R11] first error only
            // [R20] gate via first-seen flag
            if (!next_first_seen) begin
                next_err_data = rd_q.data;
                next_diag_cb = rd_q.cb;
                next_syn_first = rd_q.syn;
                next_err_type = {rd_q.multi_bit_error_flag, rd_q.err};
                next_first_seen = 1'b1;
            end
            // [R12] every error
            next_syn_last = rd_q.syn;
            // [R19] saturating count
            if (next_error_tally != CNT_MAX) begin
                next_error_tally = next_error_tally + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            err_data <= 64'h0;
            diag_cb <= 8'h00;
            syn_first <= 8'h00;
            err_type <= 2'b00;
            syn_last <= 8'h00;
            error_tally <= 4'h0;
            first_seen <= 1'b0;
        end else begin
            err_data <= next_err_data;
            diag_cb <= next_diag_cb;
            syn_first <= next_syn_first;
            err_type <= next_err_type;
            syn_last <= next_syn_last;
            error_tally <= next_error_tally;
            first_seen <= next_first_seen;
        end
    end

    // ==========================================================
    // Output stage; all data pins come from flip-flops
    logic [63:0] next_sd, wr_src, merged;
    logic [7:0] next_par, next_mcb;
    logic parity_error_flag_now;

    always_comb begin
        next_sd = 64'h0;
        // [R14] readout per mode
        if (mode_reg[MODE_RMODE_BIT]) begin
            next_sd[15:0] = mode_reg;
        end else if (mode == EMDP_MODE_ERR_DATA) begin
            // [R1] error data output
            next_sd = err_data;
        end else if (mode == EMDP_MODE_DIAG) begin
            // [R2] diagnostic word
            // [R3] checkbit-input latch path
            next_sd[DG_CBI_LO +: 8] = cbi_latch;
            next_sd[DG_CB_LO +: 8] = diag_cb;
            next_sd[DG_SYN1_LO +: 8] = syn_first;
            next_sd[DG_CNT_LO +: 4] = error_tally;
            // [R13] error type bits
            next_sd[DG_ERR_BIT] = err_type[0];
            next_sd[DG_MULTI_BIT_ERROR_FLAG_BIT] = err_type[1];
            next_sd[DG_SYN_LO +: 8] = syn_last;
        end else begin
            next_sd = rd_data;
        end
        // [R15] parity of what goes out
        next_par = byte_par(next_sd, odd_par);
        // [R9] zero source wraps back in mode 0 with buffer select low
        if (mode == EMDP_MODE_ERR_DATA && !write_buffer_select_in) begin
            wr_src = err_data;
        end else begin
            wr_src = system_data_bus_in;
        end
        for (int b = 0; b < 8; b++) begin
            merged[8*b +: 8] = byte_enables_in[b] ? wr_src[8*b +: 8]
                                                  : memory_data_bus_in[8*b +: 8];
        end
        // [R6] injected checkbits replace generated ones
        // Taken straight from the bus so the injecting write already carries them
        next_mcb = (mode == EMDP_MODE_INJECT) ? system_data_bus_in[7:0] : gen_cb(merged);
        // [R16] parity compare on writes
        // [R17] only enabled system bytes count
        parity_error_flag_now = mem_write_in && |(byte_enables_in
                   & (byte_par(system_data_bus_in, odd_par) ^ system_parity_bus_in));
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            system_data_bus_out <= 64'h0;
            system_data_bus_oe_n_out <= 1'b1;
            system_parity_bus_out <= 8'h00;
            system_parity_bus_oe_n_out <= 1'b1;
            memory_data_bus_out <= 64'h0;
            memory_checkbit_out <= 8'h00;
            error_flag_n_out <= 1'b1;
            multi_bit_error_flag_n_out <= 1'b1;
            parity_error_flag_n_out <= 1'b1;
        end else begin
            system_data_bus_out <= next_sd;
            system_data_bus_oe_n_out <= !sys_read_in;
            system_parity_bus_out <= next_par;
            system_parity_bus_oe_n_out <= !sys_read_in;
            if (mem_write_in) begin
                memory_data_bus_out <= merged;
                memory_checkbit_out <= next_mcb;
            end
            error_flag_n_out <= !(mem_read_in && rd_now.err);
            multi_bit_error_flag_n_out <= !(mem_read_in && rd_now.multi_bit_error_flag);
            parity_error_flag_n_out <= !parity_error_flag_now;
        end
    end

    // ==========================================================
    // Assertions
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_syn_rise;
        syn_s2 && !syn_s3;
    endsequence
    sequence s_first_log;
        s_syn_rise ##0 rd_q.err && !first_seen && !clr_pulse;
    endsequence

    property p_first_log;
        s_first_log |=> first_seen && err_data == $past(rd_q.data);
    endproperty
    a_first_log: assert property (p_first_log) else $error("first error not logged"); // [R10]
    property p_first_hold;
        first_seen && log_err && !clr_pulse |=> $stable(err_data) && $stable(syn_first);
    endproperty
    a_first_hold: assert property (p_first_hold) else $error("first-error regs moved"); // [R11]
    property p_cnt_inc;
        log_err && !clr_pulse && error_tally != CNT_MAX |=> error_tally == $past(error_tally) + 4'h1;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("count did not step"); // [R12]
    property p_cnt_sat;
        error_tally == CNT_MAX && !clr_pulse |=> error_tally == CNT_MAX;
    endproperty
    a_cnt_sat: assert property (p_cnt_sat) else $error("count wrapped"); // [R19]
    property p_clear;
        clr_pulse && !log_err |=> err_data == 64'h0 && error_tally == 4'h0 && !first_seen;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left state"); // [R1]
    property p_mode_cap;
        mode_register_enable_in |=> mode_reg == $past(system_data_bus_in[15:0]);
    endproperty
    a_mode_cap: assert property (p_mode_cap) else $error("mode register missed"); // [R18]
    property p_diag_cnt;
        mode == EMDP_MODE_DIAG && !mode_reg[MODE_RMODE_BIT] && !mode_register_enable_in
            |=> system_data_bus_out[DG_CNT_LO +: 4] == $past(error_tally);
    endproperty
    a_diag_cnt: assert property (p_diag_cnt) else $error("diag count wrong"); // [R2]
    property p_zero_cb;
        mem_write_in && mode == EMDP_MODE_ERR_DATA && !write_buffer_select_in
            && byte_enables_in == BE_ALL && err_data == 64'h0
            |=> memory_checkbit_out == ZERO_CHECKBITS && memory_data_bus_out == 64'h0;
    endproperty
    a_zero_cb: assert property (p_zero_cb) else $error("init checkbits wrong"); // [R8]
    property p_inject;
        mem_read_in && mode == EMDP_MODE_INJECT
            && gen_cb(memory_data_bus_in) != inj_latch |=> !error_flag_n_out;
    endproperty
    a_inject: assert property (p_inject) else $error("injection mismatch missed"); // [R7]
    property p_parity_error_flag;
        mem_write_in && (byte_enables_in & (byte_par(system_data_bus_in, odd_par)
            ^ system_parity_bus_in)) != 8'h00 |=> !parity_error_flag_n_out;
    endproperty
    a_parity_error_flag: assert property (p_parity_error_flag) else $error("parity error missed"); // [R16]
endmodule

// file: emdp_mem_model.sv
// Behavioural memory array with checkbits on the far side of the EDC block
module emdp_mem_model (
    input wire logic sys_clk_in,
    input wire logic load_in,
    input wire logic store_in,
    input wire logic [1:0] index_in,
    input wire logic [63:0] wr_data_in,
    input wire logic [7:0] wr_cb_in,
    input wire logic [71:0] flip_in,
    output logic [71:0] rd_word_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [71:0] mem [4];
    logic [71:0] last;
    // ====================
    // Array
    // Cleared at start so a partial-word merge never sees unknown bytes
    initial begin
        last = 72'h0;
        for (int i = 0; i < 4; i++) begin
            mem[i] = 72'h0;
        end
    end
    // Released bus shows the inverse of the last word, not a stale copy
    assign rd_word_out = load_in ? (mem[index_in] ^ flip_in) : ~last;
    // Word and checkbits are stored one cycle after the write request
    always @(posedge sys_clk_in) begin
        if (store_in) begin
            mem[index_in] <= {wr_cb_in, wr_data_in};
        end
        if (load_in) begin
            last <= rd_word_out;
        end
    end
endmodule

// file: tb_emdp_core.sv
// Self-checking testbench for the EDC mode, diagnostic and parity block
module tb_emdp_core;
    import emdp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, mode_register_enable = 0, srd = 0, mrd = 0, mwr = 0, wbs = 0, syc = 0;
    logic load = 0, store = 0, gp, ge, gm;
    logic [1:0] idx = 2'h0;
    logic [7:0] be = 8'h00, spar = 8'h00, paro, mcb, s1, s2, gpo;
    logic [63:0] sdi = 64'h0, sdo, mdo, mg, gsd;
    logic [71:0] flip = 72'h0, mword;
    logic sd_oe_n, par_oe_n, err_n, multi_bit_error_flag_n, parity_error_flag_n;
    logic [63:0] d1 = 64'h0123456789ABCDEF, d2 = 64'hFEDCBA9876543210;
    int num_errors = 0, total_checks = 0, cycles = 0;
    emdp_core emdp_core_inst (.sys_clk_in(clk), .rst_in(rst), .mode_register_enable_in(mode_register_enable),
        .sys_read_in(srd), .mem_read_in(mrd), .mem_write_in(mwr),
        .write_buffer_select_in(wbs), .syndrome_clock_in(syc), .byte_enables_in(be),
        .system_data_bus_in(sdi), .system_parity_bus_in(spar),
        .memory_data_bus_in(mword[63:0]), .checkbit_input_in(mword[71:64]),
        .system_data_bus_out(sdo), .system_data_bus_oe_n_out(sd_oe_n),
        .system_parity_bus_out(paro), .system_parity_bus_oe_n_out(par_oe_n),
        .memory_data_bus_out(mdo), .memory_checkbit_out(mcb), .error_flag_n_out(err_n),
        .multi_bit_error_flag_n_out(multi_bit_error_flag_n), .parity_error_flag_n_out(parity_error_flag_n));
    emdp_mem_model emdp_mem_model_inst (.sys_clk_in(clk), .load_in(load), .store_in(store),
        .index_in(idx), .wr_data_in(mdo), .wr_cb_in(mcb), .flip_in(flip), .rd_word_out(mword));
    // ====================
    // Clock and hang guard
    initial forever #5 clk = ~clk;
    // Ceiling sits well above the roughly 260 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            wrap_up();
        end
    end
    // ====================
    // Reference code and helpers
    // Columns are the ascending weight-3 or weight-5 bytes, offset by 0C
    function automatic logic [7:0] gcb(input logic [63:0] d);
        logic [7:0] c;
        int i;
        c = 8'h0C;
        i = 0;
        for (int v = 0; v < 256; v++) begin
            if (($countones(v) == 3 || $countones(v) == 5) && i < 64) begin
                if (d[i]) c ^= 8'(v);
                i++;
            end
        end
        return c;
    endfunction
    function automatic logic [7:0] gpar(input logic [63:0] d);
        logic [7:0] p;
        for (int b = 0; b < 8; b++) p[b] = ^d[8*b+:8];
        return p;
    endfunction
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic mode_wr(input logic [15:0] m);
        mode_register_enable = 1;
        sdi = {48'h0, m};
        cyc(1);
        mode_register_enable = 0;
        cyc(2);
    endtask
    task automatic rdout();
        srd = 1;
        cyc(1);
        srd = 0;
        chk("sd_oe_n", 64'h0, sd_oe_n);
        chk("par_oe_n", 64'h0, par_oe_n);
    endtask
    // Partner supplies the old word for merging; parity_error_flag stands one cycle only
    task automatic mem_wr(input logic [63:0] d, input logic [7:0] b, input logic [7:0] p,
                          input logic [1:0] i);
        mwr = 1;
        sdi = d;
        be = b;
        spar = p;
        load = 1;
        idx = i;
        cyc(1);
        gp = parity_error_flag_n;
        mwr = 0;
        load = 0;
        store = 1;
        cyc(1);
        store = 0;
    endtask
    // Flags and readout stand one cycle, so they are caught at the answering edge
    task automatic mem_rd(input logic [1:0] i, input logic [71:0] f);
        mrd = 1;
        srd = 1;
        load = 1;
        idx = i;
        flip = f;
        cyc(1);
        ge = err_n;
        gm = multi_bit_error_flag_n;
        gsd = sdo;
        gpo = paro;
        mrd = 0;
        srd = 0;
        load = 0;
        flip = 72'h0;
        cyc(1);
    endtask
    task automatic syn_pulse();
        syc = 1;
        cyc(5);
        syc = 0;
        cyc(5);
    endtask
    // ====================
    // Scenarios
    task automatic t_reset();
        chk("err_n", 64'h1, err_n);
        chk("parity_error_flag_n", 64'h1, parity_error_flag_n);
        chk("md", 64'h0, mdo);
        mode_wr(16'h0043);
        rdout();
        chk("mode", 64'h0043, sdo[15:0]);
        mode_wr(16'h0003);
        $display("test reset done");
    endtask
    task automatic t_write();
        mem_wr(d1, 8'hFF, gpar(d1), 2'h0);
        chk("parity_error_flag_n", 64'h1, gp);
        chk("md", d1, mdo);
        chk("cb", gcb(d1), mcb);
        mem_wr(d1, 8'hFF, gpar(d1) ^ 8'h01, 2'h1);
        chk("parity_error_flag_n", 64'h0, gp);
        mg = {d1[63:32], d2[31:0]};
        mem_wr(d2, 8'h0F, gpar(d2) ^ 8'hF0, 2'h0);
        chk("parity_error_flag_n", 64'h1, gp);
        chk("md", mg, mdo);
        chk("cb", gcb(mg), mcb);
        $display("test write done");
    endtask
    task automatic t_read();
        mem_rd(2'h0, 72'h0);
        chk("sd", mg, gsd);
        chk("err_n", 64'h1, ge);
        chk("par", gpar(mg), gpo);
        mem_rd(2'h0, 72'h20);
        chk("sd", mg, gsd);
        chk("err_n", 64'h0, ge);
        chk("multi_bit_error_flag_n", 64'h1, gm);
        mem_rd(2'h0, 72'h220);
        chk("multi_bit_error_flag_n", 64'h0, gm);
        mode_wr(16'h0002);
        mem_rd(2'h0, 72'h20);
        chk("sd", mg ^ 64'h20, gsd);
        chk("err_n", 64'h0, ge);
        mem_wr(d2, 8'hFF, gpar(d2), 2'h2);
        chk("cb", gcb(d2), mcb);
        // Odd parity selected: every parity bit inverts
        mode_wr(16'h0023);
        mem_rd(2'h0, 72'h0);
        chk("par_odd", {56'h0, ~gpar(mg)}, gpo);
        mem_wr(d2, 8'hFF, ~gpar(d2), 2'h2);
        chk("parity_error_flag_odd", 64'h1, gp);
        $display("test read done");
    endtask
    task automatic t_inject();
        mode_wr(16'h0004);
        mem_wr(64'h5A, 8'hFF, gpar(64'h5A), 2'h3);
        chk("cb", 64'h5A, mcb);
        mem_rd(2'h0, 72'h0);
        chk("err_n", 64'h0, ge);
        mem_wr({56'h0, gcb(mg)}, 8'hFF, gpar({56'h0, gcb(mg)}), 2'h3);
        mem_rd(2'h0, 72'h0);
        chk("err_n", 64'h1, ge);
        $display("test inject done");
    endtask
    task automatic t_diag();
        mode_wr(16'h000B);
        mem_rd(2'h0, 72'h20);
        s1 = gcb(mg ^ 64'h20) ^ gcb(mg);
        syn_pulse();
        mem_rd(2'h0, 72'h220);
        s2 = gcb(mg ^ 64'h220) ^ gcb(mg);
        syn_pulse();
        mode_wr(16'h0001);
        rdout();
        chk("diag", {26'h0, s2, 2'b01, 4'h2, s1, gcb(mg), gcb(mg)}, sdo);
        mode_wr(16'h0000);
        rdout();
        chk("err_data", mg ^ 64'h20, sdo);
        repeat (14) syn_pulse();
        mode_wr(16'h0001);
        rdout();
        chk("count", 64'hF, sdo[27:24]);
        $display("test diag done");
    endtask
    task automatic t_init();
        mode_wr(16'h0008);
        rdout();
        chk("err_data", 64'h0, sdo);
        mode_wr(16'h0001);
        rdout();
        chk("diag", 64'h0, sdo[37:8]);
        mode_wr(16'h0000);
        wbs = 0;
        mem_wr(64'hA5A5A5A5A5A5A5A5, 8'hFF, 8'h00, 2'h1);
        chk("md", 64'h0, mdo);
        chk("cb", 64'h0C, mcb);
        mode_wr(16'h0003);
        mem_rd(2'h0, 72'h220);
        syn_pulse();
        mode_wr(16'h0001);
        rdout();
        chk("type", 64'h3, sdo[29:28]);
        chk("count", 64'h1, sdo[27:24]);
        $display("test init done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ====================
    // Main sequence
    initial begin
        cyc(3);
        rst = 0;
        cyc(1);
        t_reset();
        t_write();
        t_read();
        t_inject();
        t_diag();
        t_init();
        wrap_up();
    end
endmodule
